// *** include/spd_pkg.sv ***
// Shared constants and types of the servo panel status display
package spd_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_KHZ   = 40000;
	localparam int SHOW_MS   = 1000;
	localparam int HOLD_MS   = 2000;
	localparam int IDLE_MS   = 20000;
	localparam int SHOW_CYC  = SHOW_MS * CLK_KHZ;
	localparam int HOLD_CYC  = HOLD_MS * CLK_KHZ;
	localparam int IDLE_CYC  = IDLE_MS * CLK_KHZ;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_MONSEL = 8'h04;
	localparam logic [7:0] OFS_ATTR   = 8'h08;
	localparam logic [7:0] OFS_PMIN   = 8'h0c;
	localparam logic [7:0] OFS_PMAX   = 8'h10;
	localparam logic [7:0] OFS_PRSV   = 8'h14;
	localparam logic [7:0] OFS_PVAL   = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1c;

	// Field positions
	localparam int CTRL_SERVO_ON = 0;
	localparam int CTRL_PASS_OK  = 1;
	localparam int CTRL_HEX_MON  = 2;
	localparam int ATTR_RO       = 0;
	localparam int ATTR_SON_LOCK = 1;
	localparam int ATTR_PWR_CYC  = 2;
	localparam int ATTR_WIDE     = 3;
	localparam int ATTR_HEX      = 4;
	localparam int ATTR_RSV_EN   = 5;
	localparam int STAT_RES_POS  = 8;
	localparam int STAT_MON_POS  = 16;

	// Reset values
	localparam logic [2:0]  CTRL_RST = 3'h0;
	localparam logic [5:0]  ATTR_RST = 6'h00;
	localparam logic [31:0] WORD_RST = 32'h0000_0000;

	// ==========================================================
	// Monitor codes
	localparam logic [4:0] MON_FB_USER   = 5'h00;
	localparam logic [4:0] MON_ENC_FB    = 5'h03;
	localparam logic [4:0] MON_CMD_FREQ  = 5'h06;
	localparam logic [4:0] MON_AVG_LOAD  = 5'h0c;
	localparam logic [4:0] MON_RESONANCE = 5'h11;
	localparam logic [4:0] MON_INDEX_POS = 5'h12;
	localparam logic [4:0] MON_LAST      = 5'h12;

	// Save outcome codes
	localparam logic [2:0] RES_NONE  = 3'h0;
	localparam logic [2:0] RES_SAVED = 3'h1;
	localparam logic [2:0] RES_RO    = 3'h2;
	localparam logic [2:0] RES_LOCK  = 3'h3;
	localparam logic [2:0] RES_OOR   = 3'h4;
	localparam logic [2:0] RES_SON   = 3'h5;
	localparam logic [2:0] RES_PON   = 3'h6;

	// ==========================================================
	// Glyphs: 0..15 are hex digits
	localparam logic [5:0] GL_A = 6'h0a, GL_C = 6'h0c, GL_D = 6'h0d, GL_E = 6'h0e;
	localparam logic [5:0] GL_BLANK = 6'h10, GL_MINUS = 6'h11, GL_H = 6'h12, GL_L = 6'h13;
	localparam logic [5:0] GL_N = 6'h14, GL_O = 6'h15, GL_P = 6'h16, GL_R = 6'h17;
	localparam logic [5:0] GL_T = 6'h18, GL_U = 6'h19, GL_Y = 6'h1a, GL_K = 6'h1b;
	localparam logic [5:0] GL_FIVE = 6'h05, GL_ZERO = 6'h00;

	// Five glyphs, index 4 is the leftmost digit
	typedef logic [4:0][5:0] spd_glyphs_t;

	localparam spd_glyphs_t TXT_SAVED = {GL_FIVE, GL_A, GL_U, GL_E, GL_D};
	localparam spd_glyphs_t TXT_RO    = {GL_R, GL_MINUS, GL_ZERO, GL_L, GL_Y};
	localparam spd_glyphs_t TXT_LOCK  = {GL_L, GL_O, GL_C, GL_K, GL_D};
	localparam spd_glyphs_t TXT_OOR   = {GL_ZERO, GL_U, GL_T, GL_MINUS, GL_R};
	localparam spd_glyphs_t TXT_SON   = {GL_FIVE, GL_R, GL_U, GL_O, GL_N};
	localparam spd_glyphs_t TXT_PON   = {GL_P, GL_O, GL_MINUS, GL_O, GL_N};
	localparam spd_glyphs_t TXT_PARAM = {GL_P, GL_A, GL_R, GL_A, GL_MINUS};

	typedef enum logic [5:0] {
		MD_BANNER  = 6'b000001,
		MD_MONITOR = 6'b000010,
		MD_PARAM   = 6'b000100,
		MD_EDIT    = 6'b001000,
		MD_SAVE    = 6'b010000,
		MD_ALARM   = 6'b100000
	} spd_mode_t;

	// Panel output bundle
	typedef struct packed {
		spd_glyphs_t glyph;
		logic [4:0]  dp;
		logic [4:0]  blink;
	} spd_disp_t;

	// Key bundle
	typedef struct packed {
		logic mode;
		logic shift;
		logic up;
		logic down;
		logic set;
	} spd_keys_t;

endpackage : spd_pkg

// *** core/spd_panel.sv ***
// Panel status and monitor display controller with APB register access
//
// Behaviour
// [RQ1] Set key after editing shows write outcome code for one second
// [RQ2] Successful store shows the saved code
// [RQ3] Read-only parameter rejects write and shows read-only code
// [RQ4] Wrong or missing password refuses write, shows locked code
// [RQ5] Out-of-range or reserved value refused, shows out-of-range code
// [RQ6] Servo-on-locked parameter refused while servo enabled, shows servo-on code
// [RQ7] Power-cycle parameter is stored but shows power-on code
// [RQ8] Decimal point marks high or low part of a 32-bit decimal value
// [RQ9] Negative decimal value lights the two leftmost decimal points
// [RQ10] Hexadecimal display never shows a negative sign
// [RQ11] Active alarm shows prefix symbol and three-digit alarm code
// [RQ12] Shift moves blinking digit; up and down change that digit
// [RQ13] Holding shift two seconds toggles sign of edited value
// [RQ14] Sign toggle refused when negated value leaves legal range
// [RQ15] Banner shown one second at power-up, then monitor mode
// [RQ16] Up and down step monitor code; register sets it directly
// [RQ17] Codes 0-2 select user-unit position, command and error
// [RQ18] Codes 3-5 select encoder-unit position, command and error
// [RQ19] Codes 6-11 select pulse frequency, speed and command values
// [RQ20] Codes 12-16 select loads, bus voltage, inertia, temperature
// [RQ21] Code 17 shows first resonance low, second resonance high
// [RQ22] Code 18 shows encoder count relative to index position
// [RQ23] Mode key cycles parameter, monitor, alarm; alarm skipped if none
// [RQ24] New alarm forces alarm mode; 20 s idle returns to it
// [RQ25] After save code expires, return to parameter mode
`timescale 1ns/10ps
module spd_panel
	import spd_pkg::*;
#(
	parameter int          SHOW_CYCLES = spd_pkg::SHOW_CYC,
	parameter int          HOLD_CYCLES = spd_pkg::HOLD_CYC,
	parameter int          IDLE_CYCLES = spd_pkg::IDLE_CYC,
	parameter spd_pkg::spd_glyphs_t BANNER = {6'h19, 6'h11, 6'h0d, 6'h17, 6'h19}
)(
	// Clock, reset, enable
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               ce,
	// APB slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	// Front-panel keys (pins, active high while pressed)
	input  wire spd_pkg::spd_keys_t key_pin,
	// Drive state from logic on pclk
	input  wire logic               alarm_active,
	input  wire logic [11:0]        alarm_code,
	input  wire logic [31:0]        mon_value,
	// Monitor selection and parameter store
	output logic      [4:0]         mon_code,
	output logic                    param_store,
	output logic      [31:0]        param_value,
	// Panel
	output spd_pkg::spd_disp_t      disp
);
	import spd_pkg::*;

	typedef struct packed {
		spd_mode_t         mode;
		spd_disp_t         disp;
		logic [4:0]        mon;
		logic [2:0]        ctrl;
		logic [5:0]        attr;
		logic signed [31:0] pmin;
		logic signed [31:0] pmax;
		logic signed [31:0] prsv;
		logic [31:0]       pval;
		logic signed [31:0] ed;
		logic [3:0]        cur;
		logic              hi;
		logic [31:0]       tmr;
		logic [31:0]       idle;
		logic [31:0]       hold;
		logic              hold_done;
		logic              left_alarm;
		spd_keys_t         k1;
		spd_keys_t         k2;
		spd_keys_t         k3;
		logic              alm_prev;
		logic [11:0]       code_prev;
		logic [2:0]        res;
		logic              store;
		logic [31:0]       bin;
		logic [39:0]       bw;
		logic              negw;
		logic [39:0]       bcd;
		logic              neg;
		logic [5:0]        bcnt;
		logic [31:0]       rdata;
		logic              rdy;
		logic              err;
	} spd_state_t;

	spd_state_t r;
	spd_state_t next_r;

	// ==========================================================
	// Helpers
	function automatic logic [31:0] spd_pow10(input logic [3:0] n);
		case (n)
			4'h0:    spd_pow10 = 32'h0000_0001;
			4'h1:    spd_pow10 = 32'h0000_000a;
			4'h2:    spd_pow10 = 32'h0000_0064;
			4'h3:    spd_pow10 = 32'h0000_03e8;
			4'h4:    spd_pow10 = 32'h0000_2710;
			4'h5:    spd_pow10 = 32'h0001_86a0;
			4'h6:    spd_pow10 = 32'h000f_4240;
			4'h7:    spd_pow10 = 32'h0098_9680;
			4'h8:    spd_pow10 = 32'h05f5_e100;
			default: spd_pow10 = 32'h3b9a_ca00;
		endcase
	endfunction : spd_pow10

	spd_keys_t   press;
	logic        hexf;
	logic        wide;
	logic        sub_hi;
	logic [3:0]  pos;
	logic [31:0] src;
	logic [31:0] step;
	logic [3:0]  cur_max;
	logic signed [31:0] negv;
	logic        any_key;
	logic        new_alarm;
	logic        acc;
	logic [39:0] adj;
	logic [4:0]  part;

	always_comb
	begin
		next_r    = r;
		press     = r.k2 & ~r.k3;
		any_key   = |r.k2;
		new_alarm = alarm_active & (~r.alm_prev | (alarm_code != r.code_prev));
		hexf      = (r.mode == MD_EDIT) ? r.attr[ATTR_HEX] : r.ctrl[CTRL_HEX_MON];
		wide      = (r.mode == MD_EDIT) ? r.attr[ATTR_WIDE] : 1'b1;
		cur_max   = wide ? (hexf ? 4'h7 : 4'h9) : (hexf ? 4'h3 : 4'h4);
		step      = hexf ? (32'h1 << {r.cur, 2'b00}) : spd_pow10(r.cur);
		negv      = -r.ed;
		src       = (r.mode == MD_EDIT) ? r.ed : mon_value;
		adj       = r.bw;
		acc       = psel & penable & ~r.rdy;
		next_r.store = 1'b0;

		// Key synchronisers and same-clock drive inputs
		next_r.k1        = key_pin;
		next_r.k2        = r.k1;
		next_r.k3        = r.k2;
		next_r.alm_prev  = alarm_active;
		next_r.code_prev = alarm_code;

		// ==========================================================
		// Timers
		next_r.tmr  = (r.tmr != 32'h0) ? r.tmr - 32'h1 : 32'h0;
		next_r.idle = (any_key || r.idle == 32'h0) ? IDLE_CYCLES[31:0] : r.idle - 32'h1;
		if (!r.k2.shift)
		begin
			next_r.hold      = 32'h0;
			next_r.hold_done = 1'b0;
		end
		else if (!r.hold_done)
			next_r.hold = r.hold + 32'h1;

		// ==========================================================
		// Mode machine
		case (r.mode)
			MD_BANNER:
				if (r.tmr == 32'h0)
					next_r.mode = MD_MONITOR; // RQ15
			MD_MONITOR:
			begin
				if (press.up) // RQ16
					next_r.mon = (r.mon == MON_LAST) ? MON_FB_USER : r.mon + 5'h1;
				else if (press.down) // RQ16
					next_r.mon = (r.mon == MON_FB_USER) ? MON_LAST : r.mon - 5'h1;
				if (press.set)
					next_r.ctrl[CTRL_HEX_MON] = ~r.ctrl[CTRL_HEX_MON];
				if (press.shift)
					next_r.hi = ~r.hi;
				if (press.mode)
					next_r.mode = alarm_active ? MD_ALARM : MD_PARAM; // RQ23
			end
			MD_PARAM:
				if (press.set)
				begin
					next_r.mode = MD_EDIT;
					next_r.ed   = r.pval;
					next_r.cur  = 4'h0;
				end
				else if (press.mode)
					next_r.mode = MD_MONITOR; // RQ23
			MD_EDIT:
			begin
				if (press.shift) // RQ12
					next_r.cur = (r.cur >= cur_max) ? 4'h0 : r.cur + 4'h1;
				if (press.up) // RQ12
					next_r.ed = r.ed + step;
				else if (press.down) // RQ12
					next_r.ed = r.ed - step;
				if (r.k2.shift && !r.hold_done && r.hold >= HOLD_CYCLES[31:0] - 32'h1)
				begin
					next_r.hold_done = 1'b1;
					if (negv >= r.pmin && negv <= r.pmax) // RQ14
						next_r.ed = negv; // RQ13
				end
				if (press.mode)
					next_r.mode = MD_PARAM;
				else if (press.set)
				begin
					next_r.mode = MD_SAVE;
					next_r.tmr  = SHOW_CYCLES[31:0]; // RQ1
					if (r.attr[ATTR_RO])
						next_r.res = RES_RO; // RQ3
					else if (!r.ctrl[CTRL_PASS_OK])
						next_r.res = RES_LOCK; // RQ4
					else if (r.ed < r.pmin || r.ed > r.pmax
						|| (r.attr[ATTR_RSV_EN] && r.ed == r.prsv))
						next_r.res = RES_OOR; // RQ5
					else if (r.ctrl[CTRL_SERVO_ON] && r.attr[ATTR_SON_LOCK])
						next_r.res = RES_SON; // RQ6
					else
					begin
						next_r.pval  = r.ed;
						next_r.store = 1'b1;
						next_r.res   = r.attr[ATTR_PWR_CYC] ? RES_PON : RES_SAVED; // RQ2 RQ7
					end
				end
			end
			MD_SAVE:
				if (r.tmr == 32'h0)
					next_r.mode = MD_PARAM; // RQ25
			MD_ALARM:
				if (press.mode)
				begin
					next_r.mode       = MD_PARAM; // RQ23
					next_r.left_alarm = 1'b1;
				end
			default:
				next_r.mode = MD_MONITOR;
		endcase

		// Alarm forcing overrides the mode set by any key action this cycle; that key's store or edit still happens
		if (new_alarm)
		begin
			next_r.mode       = MD_ALARM; // RQ24
			next_r.left_alarm = 1'b0;
		end
		else if (r.left_alarm && alarm_active && r.idle == 32'h1
			&& r.mode != MD_ALARM && !any_key)
		begin
			next_r.mode       = MD_ALARM; // RQ24
			next_r.left_alarm = 1'b0;
		end
		if (!alarm_active)
			next_r.left_alarm = 1'b0;

		// ==========================================================
		// Binary to BCD, one bit per cycle, result latched every 33 cycles
		if (r.bcnt == 6'h0)
		begin
			next_r.negw = src[31] & ~hexf; // RQ10
			next_r.bin  = src[31] ? (32'h0 - src) : src;
			next_r.bw   = 40'h0;
			next_r.bcnt = 6'h20;
		end
		else
		begin
			for (int i = 0; i < 10; i++)
				if (r.bw[i*4 +: 4] >= 4'h5)
					adj[i*4 +: 4] = r.bw[i*4 +: 4] + 4'h3;
			{next_r.bw, next_r.bin} = {adj[38:0], r.bin, 1'b0};
			next_r.bcnt = r.bcnt - 6'h1;
			if (r.bcnt == 6'h1)
			begin
				next_r.bcd = {adj[38:0], r.bin[31]};
				next_r.neg = r.negw;
			end
		end

		// ==========================================================
		// Display rendering
		sub_hi = (r.mode == MD_EDIT) ? (wide && r.cur > (hexf ? 4'h3 : 4'h4)) : r.hi;
		pos    = (r.mode == MD_EDIT && sub_hi) ? r.cur - (hexf ? 4'h4 : 4'h5) : r.cur;
		part   = 5'h0;
		next_r.disp.dp    = 5'h0;
		next_r.disp.blink = 5'h0;
		case (r.mode)
			MD_BANNER: next_r.disp.glyph = BANNER; // RQ15
			MD_PARAM:  next_r.disp.glyph = TXT_PARAM;
			MD_SAVE:
				case (r.res) // RQ1
					RES_RO:   next_r.disp.glyph = TXT_RO;
					RES_LOCK: next_r.disp.glyph = TXT_LOCK;
					RES_OOR:  next_r.disp.glyph = TXT_OOR;
					RES_SON:  next_r.disp.glyph = TXT_SON;
					RES_PON:  next_r.disp.glyph = TXT_PON;
					default:  next_r.disp.glyph = TXT_SAVED;
				endcase
			MD_ALARM: // RQ11
				next_r.disp.glyph = {GL_A, GL_L, {2'b00, alarm_code[11:8]},
					{2'b00, alarm_code[7:4]}, {2'b00, alarm_code[3:0]}};
			default:
			begin
				if (hexf) // RQ10
				begin
					next_r.disp.glyph[4] = !wide ? GL_BLANK : (sub_hi ? GL_H : GL_L);
					for (int i = 0; i < 4; i++)
						next_r.disp.glyph[i] = {2'b00, src[(sub_hi ? 16 : 0) + i*4 +: 4]};
				end
				else
				begin
					for (int i = 0; i < 5; i++)
						next_r.disp.glyph[i] = {2'b00, r.bcd[(sub_hi ? 20 : 0) + i*4 +: 4]};
					if (wide && sub_hi)
						part[0] = 1'b1; // RQ8
					if (r.neg)
						part[4:3] = 2'b11; // RQ9
				end
				next_r.disp.dp = part;
				if (r.mode == MD_EDIT)
					next_r.disp.blink = 5'h1 << pos[2:0]; // RQ12
			end
		endcase

		// ==========================================================
		// APB slave: one wait state, answer registered
		next_r.rdy = acc;
		next_r.err = 1'b0;
		if (acc)
		begin
			next_r.rdata = 32'h0;
			if (paddr == OFS_CTRL)
			begin
				next_r.rdata = {29'h0, r.ctrl};
				if (pwrite)
					next_r.ctrl = pwdata[2:0];
			end
			else if (paddr == OFS_MONSEL)
			begin
				next_r.rdata = {27'h0, r.mon};
				if (pwrite && pwdata[4:0] <= MON_LAST)
					next_r.mon = pwdata[4:0]; // RQ16
			end
			else if (paddr == OFS_ATTR)
			begin
				next_r.rdata = {26'h0, r.attr};
				if (pwrite)
					next_r.attr = pwdata[5:0];
			end
			else if (paddr == OFS_PMIN)
			begin
				next_r.rdata = r.pmin;
				if (pwrite)
					next_r.pmin = pwdata;
			end
			else if (paddr == OFS_PMAX)
			begin
				next_r.rdata = r.pmax;
				if (pwrite)
					next_r.pmax = pwdata;
			end
			else if (paddr == OFS_PRSV)
			begin
				next_r.rdata = r.prsv;
				if (pwrite)
					next_r.prsv = pwdata;
			end
			else if (paddr == OFS_PVAL)
			begin
				next_r.rdata = r.pval;
				// The panel's own store in the same cycle wins over software
				if (pwrite && !next_r.store)
					next_r.pval = pwdata;
			end
			else if (paddr == OFS_STATUS)
				next_r.rdata = {11'h0, r.mon, 5'h0, r.res, 2'h0, r.mode};
			else
				next_r.err = 1'b1;
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r      <= '0;
			r.mode <= MD_BANNER;
			r.tmr  <= SHOW_CYCLES[31:0];
			r.idle <= IDLE_CYCLES[31:0];
			r.ctrl <= CTRL_RST;
			r.attr <= ATTR_RST;
			r.pval <= WORD_RST;
			r.disp.glyph <= BANNER;
		end
		else if (ce)
			r <= next_r;
	end

	// Monitor selection drives the value mux in the drive datapath:
	// 0-2 user units, 3-5 encoder units, 6-11 command and speed,
	// 12-16 load and power stage, 17 resonances, 18 index-relative count
	assign mon_code    = r.mon; // RQ17 RQ18 RQ19 RQ20 RQ21 RQ22
	assign param_store = r.store;
	assign param_value = r.pval;
	assign disp        = r.disp;
	assign prdata      = r.rdata;
	assign pready      = r.rdy;
	assign pslverr     = r.err;

endmodule : spd_panel

// *** verif/spd_panel_assertions.sv ***
// Concurrent checks on the panel controller ports
`timescale 1ns/10ps
module spd_panel_checker
	import spd_pkg::*;
#(
	parameter spd_pkg::spd_glyphs_t BANNER = '0
)(
	// Clock and reset
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               ce,
	// APB
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [7:0]         paddr,
	input wire logic [31:0]        pwdata,
	input wire logic [31:0]        prdata,
	input wire logic               pready,
	input wire logic               pslverr,
	// Drive state and panel
	input wire logic               alarm_active,
	input wire logic [4:0]         mon_code,
	input wire logic               param_store,
	input wire spd_pkg::spd_disp_t disp
);
	import spd_pkg::*;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ==========================================================
	// Sequences
	sequence s_access;
		psel && penable && ce && !pready;
	endsequence
	sequence s_code_shown;
		##[1:2] (disp.glyph == TXT_SAVED || disp.glyph == TXT_PON);
	endsequence
	sequence s_monsel_write;
		psel && penable && pwrite && pready && paddr == OFS_MONSEL && pwdata <= 32'd18;
	endsequence

	// ==========================================================
	// Bus answers
	a_ready_wait: assert property (s_access |=> pready)
		else $error("access not answered after one wait state");
	a_ready_one: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	a_ready_cause: assert property (pready |-> $past(psel) && $past(penable))
		else $error("ready without an access phase");
	a_slverr_zero: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error answer without ready or with data");

	// ==========================================================
	// Panel behaviour
	a_store_code: assert property (param_store |-> s_code_shown)
		else $error("store not followed by saved or power-on code");
	a_store_once: assert property (param_store |=> !param_store)
		else $error("store pulse longer than one cycle");
	a_banner_reset: assert property ($rose(presetn) |-> disp.glyph == BANNER && disp.dp == 5'h00)
		else $error("banner not shown out of reset");
	a_mon_write: assert property (s_monsel_write |=> {27'h0, mon_code} == $past(pwdata))
		else $error("monitor code not taken from register write");
	a_mon_range: assert property (mon_code <= MON_LAST)
		else $error("monitor code beyond last code");
	a_alarm_force: assert property (ce && $rose(alarm_active) |->
		##[1:3] (disp.glyph[4] == GL_A && disp.glyph[3] == GL_L))
		else $error("new alarm did not force alarm display");
endmodule : spd_panel_checker

bind spd_panel spd_panel_checker #(.BANNER(BANNER)) i_spd_panel_checker (
	.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .alarm_active(alarm_active), .mon_code(mon_code),
	.param_store(param_store), .disp(disp)
);

// *** verif/spd_operator.sv ***
// Behavioural panel operator pressing the front keys
`timescale 1ns/10ps
module spd_operator
	import spd_pkg::*;
(
	// Clock
	input  wire logic          pclk,
	// Keys
	output spd_pkg::spd_keys_t key_pin
);
	import spd_pkg::*;

	initial key_pin = '0;

	// Key 4 mode, 3 shift, 2 up, 1 down, 0 set; the gap lets the synchroniser see a release
	task press(input int k, input int n);
		key_pin <= spd_keys_t'(5'h01 << k);
		repeat (n) @(posedge pclk);
		key_pin <= '0;
		repeat (10) @(posedge pclk);
	endtask : press
endmodule : spd_operator

// *** verif/test_servo_panel_status_display.sv ***
// Self-checking bench of the panel status display controller
`timescale 1ns/10ps
module test_servo_panel_status_display;
	import spd_pkg::*;

	// ==========================================================
	// Shortened counts keep the run small
	localparam int SHOW = 50;
	localparam int HOLD = 40;
	localparam int IDLE = 200;
	localparam spd_glyphs_t BN = {GL_P, GL_A, GL_N, GL_E, GL_L};

	logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
	logic        alarm_active, param_store;
	logic [7:0]  paddr;
	logic [11:0] alarm_code;
	logic [31:0] pwdata, prdata, rd, mon_value, param_value;
	logic [4:0]  mon_code;
	spd_keys_t   key_pin;
	spd_disp_t   disp;
	int          mismatches, num_checks, stores, i;

	spd_panel #(.SHOW_CYCLES(SHOW), .HOLD_CYCLES(HOLD), .IDLE_CYCLES(IDLE), .BANNER(BN)) i_spd_panel (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .key_pin(key_pin), .alarm_active(alarm_active),
		.alarm_code(alarm_code), .mon_value(mon_value), .mon_code(mon_code),
		.param_store(param_store), .param_value(param_value), .disp(disp));
	spd_operator i_spd_operator (.pclk(pclk), .key_pin(key_pin));

	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	always @(posedge pclk)
		if (param_store === 1'b1) stores++;

	// ==========================================================
	// Tasks
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// Idle cycle after release so back-to-back calls never drive a signal twice in a step
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) mismatches++;
		@(posedge pclk);
	endtask : apb

	task stat(input string nm, input logic [31:0] mask, input logic [31:0] exp);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(nm, rd & mask, exp);
	endtask : stat

	task key(input int k, input int n);
		i_spd_operator.press(k, n);
	endtask : key

	task setup(input logic [31:0] c, at, lo, hi, v);
		apb(1'b1, OFS_CTRL, c);
		apb(1'b1, OFS_ATTR, at);
		apb(1'b1, OFS_PMIN, lo);
		apb(1'b1, OFS_PMAX, hi);
		apb(1'b1, OFS_PVAL, v);
	endtask : setup

	task save_case(input logic [31:0] c, at, lo, hi, input logic [2:0] res);
		int s0;
		setup(c, at, lo, hi, 32'h3);
		s0 = stores;
		key(0, 4);
		key(0, 4);
		stat("save status", 32'h73f, (32'(res) << 8) | 32'h10);
		chk("store count", stores - s0, 32'(res == RES_SAVED || res == RES_PON));
		repeat (SHOW + 10) @(posedge pclk);
		stat("after save", 32'h3f, 32'h4);
	endtask : save_case

	task end_sim;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim

	initial
	begin
		repeat (12000) @(posedge pclk);
		mismatches++;
		end_sim;
	end

	// ==========================================================
	// Main sequence
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{alarm_active, alarm_code, mon_value} = '0;
		ce = 1'b1;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("banner", 32'(disp.glyph == BN), 32'h1);
		// Enable low must hold the banner timer where it is
		ce <= 1'b0;
		repeat (SHOW + 10) @(posedge pclk);
		chk("frozen banner", 32'(disp.glyph == BN), 32'h1);
		ce <= 1'b1;
		stat("banner mode", 32'h3f, 32'h1);
		repeat (SHOW + 5) @(posedge pclk);
		stat("monitor mode", 32'h3f, 32'h2);
		for (i = 0; i <= 18; i++)
		begin
			apb(1'b1, OFS_MONSEL, 32'(i));
			chk("monitor code", 32'(mon_code), 32'(i));
		end
		apb(1'b1, OFS_MONSEL, 32'd19);
		chk("monitor code refused", 32'(mon_code), 32'd18);
		key(2, 4);
		chk("monitor wrap", 32'(mon_code), 32'd0);
		key(1, 4);
		chk("monitor step down", 32'(mon_code), 32'd18);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped error", {31'h0, err}, 32'h1);
		chk("unmapped data", rd, 32'h0);
		mon_value <= 32'd1234567890;
		repeat (70) @(posedge pclk);
		chk("low part point", {31'h0, disp.dp[0]}, 32'h0);
		chk("low digits", 32'(disp.glyph == {6'h06, 6'h07, 6'h08, 6'h09, 6'h00}), 32'h1);
		key(3, 4);
		repeat (70) @(posedge pclk);
		chk("high low point", {31'h0, disp.dp[0]}, 32'h1);
		chk("high digits", 32'(disp.glyph == {6'h01, 6'h02, 6'h03, 6'h04, 6'h05}), 32'h1);
		mon_value <= 32'hffff_fffb;
		repeat (70) @(posedge pclk);
		chk("negative points", {30'h0, disp.dp[4:3]}, 32'h3);
		key(0, 4);
		apb(1'b0, OFS_CTRL, 32'h0);
		chk("set toggles hex", rd, 32'h4);
		repeat (70) @(posedge pclk);
		chk("hex no sign", 32'(disp.dp[4:3] == 2'b11), 32'h0);
		chk("hex high", 32'(disp.glyph == {GL_H, 6'h0f, 6'h0f, 6'h0f, 6'h0f}), 32'h1);
		key(4, 4);
		stat("param mode", 32'h3f, 32'h4);
		key(4, 4);
		stat("back to monitor", 32'h3f, 32'h2);
		key(4, 4);
		save_case(32'h2, 32'h0, 32'h0, 32'h9, RES_SAVED);
		chk("stored value", param_value, 32'h3);
		save_case(32'h2, 32'h1, 32'h0, 32'h9, RES_RO);
		save_case(32'h0, 32'h0, 32'h0, 32'h9, RES_LOCK);
		save_case(32'h2, 32'h0, 32'h5, 32'h9, RES_OOR);
		apb(1'b1, OFS_PRSV, 32'h3);
		save_case(32'h2, 32'h20, 32'h0, 32'h9, RES_OOR);
		save_case(32'h3, 32'h2, 32'h0, 32'h9, RES_SON);
		save_case(32'h2, 32'h4, 32'h0, 32'h9, RES_PON);
		setup(32'h2, 32'h0, 32'hffff_fff7, 32'h9, 32'h3);
		key(0, 4);
		key(3, HOLD + 5);
		key(0, 4);
		chk("sign toggled", param_value, 32'hffff_fffd);
		repeat (SHOW + 10) @(posedge pclk);
		setup(32'h2, 32'h0, 32'h0, 32'h9, 32'h3);
		key(0, 4);
		key(3, HOLD + 5);
		key(0, 4);
		chk("sign refused", param_value, 32'h3);
		repeat (SHOW + 10) @(posedge pclk);
		setup(32'h2, 32'h0, 32'h0, 32'd99, 32'h3);
		key(0, 4);
		key(2, 4);
		key(3, 4);
		chk("blink moved", {31'h0, disp.blink[1]}, 32'h1);
		key(2, 4);
		key(0, 4);
		chk("digit edit", param_value, 32'd14);
		repeat (SHOW + 10) @(posedge pclk);
		alarm_code <= 12'h123;
		alarm_active <= 1'b1;
		repeat (4) @(posedge pclk);
		chk("alarm glyphs", 32'(disp.glyph[4:3] == {GL_A, GL_L}), 32'h1);
		chk("alarm digits", 32'(disp.glyph[2:0] == {6'h01, 6'h02, 6'h03}), 32'h1);
		stat("alarm mode", 32'h3f, 32'h20);
		key(4, 4);
		stat("alarm to param", 32'h3f, 32'h4);
		repeat (IDLE + 10) @(posedge pclk);
		stat("idle return", 32'h3f, 32'h20);
		end_sim;
	end
endmodule : test_servo_panel_status_display
